// ==== sprx_pkg.sv ====
package sprx_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int SPRX_ADDR_W = 16;
  localparam int SPRX_DATA_W = 32;
  localparam int SPRX_IDX_W = 14;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [13:0] SPRX_IDX_ENABLE = 14'h2a01;
  localparam logic [13:0] SPRX_IDX_PW [0:2] = '{14'h2a02, 14'h2a05, 14'h2a08};
  localparam logic [13:0] SPRX_IDX_SH [0:2] = '{14'h2a03, 14'h2a06, 14'h2a09};
  localparam logic [13:0] SPRX_IDX_SL [0:2] = '{14'h2a04, 14'h2a07, 14'h2a0a};
  localparam logic [13:0] SPRX_IDX_CTRL = 14'h2a30;
  localparam logic [13:0] SPRX_IDX_STATUS = 14'h2a31;
  localparam logic [13:0] SPRX_IDX_DATA = 14'h2a32;

  // ****************************************************************
  // Reset values and field layout
  // ****************************************************************
  localparam logic [7:0] SPRX_ENABLE_RST = 8'h00;
  localparam logic [7:0] SPRX_PW_RST = 8'h03;
  localparam logic [7:0] SPRX_START_RST = 8'h00;
  localparam logic [7:0] SPRX_CTRL_RST = 8'h00;
  localparam logic [7:0] SPRX_PW_MASK = 8'h43;
  localparam logic [7:0] SPRX_SH_MASK = 8'h01;
  localparam logic [7:0] SPRX_CTRL_MASK = 8'h01;
  localparam int SPRX_EN_P0_LSB = 2;
  localparam int SPRX_EN_P1_LSB = 6;
  localparam int SPRX_RATE0_BIT = 0;
  localparam int SPRX_RATE1_BIT = 1;
  localparam int SPRX_AP_BIT = 6;
  localparam int SPRX_SPLIT_BIT = 0;

  // ****************************************************************
  // Channels
  // ****************************************************************
  localparam int SPRX_P0_CH = 3;
  localparam int SPRX_P1_CH = 2;
  localparam int SPRX_NUM_CH = 5;
  localparam logic [8:0] SPRX_P1_START [0:1] = '{9'h000, 9'h020};
  localparam logic [1:0] SPRX_P1_AP = 2'b10;

  localparam logic [1:0] SPRX_RES_8 = 2'b00;
  localparam logic [1:0] SPRX_RES_16 = 2'b01;
  localparam logic [1:0] SPRX_RES_24 = 2'b10;
  localparam logic [1:0] SPRX_RES_32 = 2'b11;

  typedef struct packed {
    logic split;
    logic [7:0] enable;
    logic [2:0] ap;
    logic [5:0] width;
    logic [26:0] start;
  } sprx_cfg_t;

  function automatic logic [5:0] sprx_res_bits(input logic [1:0] code);
    logic [5:0] n;
    n = 6'h20;
    case (code)
      SPRX_RES_8: n = 6'h08;
      SPRX_RES_16: n = 6'h10;
      SPRX_RES_24: n = 6'h18;
      default: n = 6'h20;
    endcase
    return n;
  endfunction

endpackage

// ==== sprx_sync.sv ====
`timescale 1ns/1ps
module sprx_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ==== sprx_slot_capture.sv ====
`timescale 1ns/1ps
module sprx_slot_capture
  import sprx_pkg::*;
#(
  parameter int WORD_W = 32
) (
  input wire logic bclk,
  input wire logic lk_rst_n,
  input wire logic sd_i,
  input wire logic sof_i,
  input wire logic en_i,
  input wire logic [1:0] width_i,
  input wire logic [8:0] start_i,
  output logic [WORD_W-1:0] word_o,
  output logic done_tog_o
);

  logic [9:0] pos_reg;
  logic [9:0] pos_now;
  logic [5:0] nbits;
  logic first_bit;
  logic cap_reg;
  logic [5:0] taken_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;
  logic done_now;

  assign pos_now = sof_i ? 10'h000 : pos_reg;
  assign nbits = sprx_res_bits(width_i);
  assign first_bit = en_i && (pos_now == {1'b0, start_i});
  assign shift_next = {shift_reg[WORD_W-2:0], sd_i};
  assign done_now = cap_reg && !sof_i && !first_bit && ((taken_reg + 6'h01) == nbits);

  // ****************************************************************
  // Bit position since start of frame
  // ****************************************************************
  always_ff @(posedge bclk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      pos_reg <= 10'h000;
    end else if (pos_now != 10'h3ff) begin
      pos_reg <= pos_now + 10'h001;
    end else begin
      pos_reg <= pos_now;
    end
  end

  // ****************************************************************
  // Shifting
  // ****************************************************************
  always_ff @(posedge bclk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      cap_reg <= 1'b0;
      taken_reg <= 6'h00;
      shift_reg <= '0;
    end else if (first_bit) begin
      cap_reg <= 1'b1;
      taken_reg <= 6'h01;
      shift_reg <= {{(WORD_W-1){1'b0}}, sd_i};
    end else if (cap_reg && sof_i) begin
      // New frame before the slot completed: drop the partial sample
      cap_reg <= 1'b0;
    end else if (cap_reg) begin
      shift_reg <= shift_next;
      taken_reg <= taken_reg + 6'h01;
      if (done_now) begin
        cap_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge bclk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      word_o <= '0;
      done_tog_o <= 1'b0;
    end else if (done_now) begin
      word_o <= shift_next;
      done_tog_o <= ~done_tog_o;
    end
  end

  width_len_a: assert property (@(posedge bclk) disable iff (!lk_rst_n)
    $changed(done_tog_o) |-> ($past(taken_reg) + 6'h01) == $past(nbits))
    else $error("sample length differs from selected width");

  gate_off_a: assert property (@(posedge bclk) disable iff (!lk_rst_n)
    !en_i && !cap_reg |=> !cap_reg)
    else $error("disabled channel started capturing");

  start_pos_a: assert property (@(posedge bclk) disable iff (!lk_rst_n)
    $rose(cap_reg) |-> $past(pos_now) == {1'b0, $past(start_i)})
    else $error("capture began away from start offset");

endmodule

// ==== sprx_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Bits 7:6 enable second path buffers
// - Bits 4:2 enable first path buffers
// - Bit 1 doubles second path rate
// - Bit 0 doubles first path rate
// - Phase bit used only split, single rate
// - Phase zero low half, one high half
// - Width code gives 8/16/24/32 bits
// - Start-high bit 0 is offset MSB
// - Start-low gives lower eight offset bits
module sprx_top
  import sprx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SPRX_ADDR_W-1:0] paddr,
  input wire logic [SPRX_DATA_W-1:0] pwdata,
  output logic [SPRX_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bclk,
  input wire logic frame_sync,
  input wire logic sdata
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] enable_reg;
  logic [7:0] pw_reg [0:SPRX_P0_CH-1];
  logic [7:0] sh_reg [0:SPRX_P0_CH-1];
  logic [7:0] sl_reg [0:SPRX_P0_CH-1];
  logic [7:0] ctrl_reg;
  logic [SPRX_NUM_CH-1:0] status_reg;
  logic [SPRX_DATA_W-1:0] data_reg [0:SPRX_NUM_CH-1];
  logic [SPRX_DATA_W-1:0] prdata_reg;
  logic pslverr_reg;
  logic [SPRX_IDX_W-1:0] word_idx;
  logic [SPRX_DATA_W-1:0] rd_val;
  logic hit;
  logic setup_ph;
  logic wr_en;
  sprx_cfg_t cfg_p;
  sprx_cfg_t cfg_s;
  logic [SPRX_NUM_CH-1:0] done_s;
  logic [SPRX_NUM_CH-1:0] done_prev_reg;
  logic [SPRX_NUM_CH-1:0] new_smp;
  logic [SPRX_NUM_CH-1:0] clr_smp;

  logic lk_rst_n;
  sprx_cfg_t cfg_s_d_reg;
  sprx_cfg_t lk_cfg_reg;
  logic fs_m_reg;
  logic sd_m_reg;
  logic fs_q_reg;
  logic fs_d_reg;
  logic sd_q_reg;
  logic fs_rise;
  logic fs_fall;
  logic [SPRX_NUM_CH-1:0] ch_sof;
  logic [SPRX_NUM_CH-1:0] ch_en;
  logic [1:0] ch_width [0:SPRX_NUM_CH-1];
  logic [8:0] ch_start [0:SPRX_NUM_CH-1];
  logic [SPRX_DATA_W-1:0] lk_word [0:SPRX_NUM_CH-1];
  logic [SPRX_NUM_CH-1:0] lk_done_tog;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign word_idx = paddr[SPRX_ADDR_W-1:2];
  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pwrite && hit;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (word_idx == SPRX_IDX_ENABLE) begin
      hit = 1'b1;
      rd_val = {24'h00_0000, enable_reg};
    end else if (word_idx == SPRX_IDX_CTRL) begin
      hit = 1'b1;
      rd_val = {24'h00_0000, ctrl_reg};
    end else if (word_idx == SPRX_IDX_STATUS) begin
      hit = 1'b1;
      rd_val = {27'h000_0000, status_reg};
    end else begin
      for (int i = 0; i < SPRX_P0_CH; i++) begin
        if (word_idx == SPRX_IDX_PW[i]) begin
          hit = 1'b1;
          rd_val = {24'h00_0000, pw_reg[i]};
        end else if (word_idx == SPRX_IDX_SH[i]) begin
          hit = 1'b1;
          rd_val = {24'h00_0000, sh_reg[i]};
        end else if (word_idx == SPRX_IDX_SL[i]) begin
          hit = 1'b1;
          rd_val = {24'h00_0000, sl_reg[i]};
        end
      end
      for (int i = 0; i < SPRX_NUM_CH; i++) begin
        if (word_idx == (SPRX_IDX_DATA + SPRX_IDX_W'(i))) begin
          hit = 1'b1;
          rd_val = data_reg[i];
        end
      end
    end
  end

  // Read data and error are taken in the setup cycle, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_reg <= !hit;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= SPRX_ENABLE_RST;
      ctrl_reg <= SPRX_CTRL_RST;
    end else if (wr_en && word_idx == SPRX_IDX_ENABLE) begin
      enable_reg <= pwdata[7:0];
    end else if (wr_en && word_idx == SPRX_IDX_CTRL) begin
      ctrl_reg <= pwdata[7:0] & SPRX_CTRL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SPRX_P0_CH; i++) begin
        pw_reg[i] <= SPRX_PW_RST;
        sh_reg[i] <= SPRX_START_RST;
        sl_reg[i] <= SPRX_START_RST;
      end
    end else if (wr_en) begin
      for (int i = 0; i < SPRX_P0_CH; i++) begin
        if (word_idx == SPRX_IDX_PW[i]) begin
          pw_reg[i] <= pwdata[7:0] & SPRX_PW_MASK;
        end
        if (word_idx == SPRX_IDX_SH[i]) begin
          sh_reg[i] <= pwdata[7:0] & SPRX_SH_MASK;
        end
        if (word_idx == SPRX_IDX_SL[i]) begin
          sl_reg[i] <= pwdata[7:0];
        end
      end
    end
  end

  // ****************************************************************
  // Configuration bundle towards the link
  // ****************************************************************
  always_comb begin
    cfg_p.split = ctrl_reg[SPRX_SPLIT_BIT];
    cfg_p.enable = enable_reg;
    for (int i = 0; i < SPRX_P0_CH; i++) begin
      cfg_p.ap[i] = pw_reg[i][SPRX_AP_BIT];
      cfg_p.width[2*i +: 2] = pw_reg[i][1:0];
      cfg_p.start[9*i +: 9] = {sh_reg[i][0], sl_reg[i]};
    end
  end

  sprx_sync #(.W($bits(sprx_cfg_t))) u_cfg_sync (
    .clk(bclk),
    .rst_n(lk_rst_n),
    .d(cfg_p),
    .q(cfg_s)
  );

  // ****************************************************************
  // Captured samples back to the bus side
  // ****************************************************************
  sprx_sync #(.W(SPRX_NUM_CH)) u_done_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(lk_done_tog),
    .q(done_s)
  );

  assign new_smp = done_s ^ done_prev_reg;
  assign clr_smp = (wr_en && word_idx == SPRX_IDX_STATUS) ? pwdata[SPRX_NUM_CH-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_prev_reg <= '0;
      status_reg <= '0;
    end else begin
      done_prev_reg <= done_s;
      // A new sample outweighs a clear in the same cycle
      status_reg <= (status_reg & ~clr_smp) | new_smp;
    end
  end

  // The link word has stood still since its toggle, so it is safe to take here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SPRX_NUM_CH; i++) begin
        data_reg[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < SPRX_NUM_CH; i++) begin
        if (new_smp[i]) begin
          data_reg[i] <= lk_word[i];
        end
      end
    end
  end

  // ****************************************************************
  // Link domain
  // ****************************************************************
  sprx_sync #(.W(1)) u_lk_rst (
    .clk(bclk),
    .rst_n(presetn),
    .d(1'b1),
    .q(lk_rst_n)
  );

  // Settings are adopted only once two synchronised samples agree
  always_ff @(posedge bclk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      cfg_s_d_reg <= '0;
      lk_cfg_reg <= '0;
    end else begin
      cfg_s_d_reg <= cfg_s;
      if (cfg_s == cfg_s_d_reg) begin
        lk_cfg_reg <= cfg_s;
      end
    end
  end

  // Pins pass two stages before any logic reads them
  always_ff @(posedge bclk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      fs_m_reg <= 1'b0;
      sd_m_reg <= 1'b0;
      fs_q_reg <= 1'b0;
      fs_d_reg <= 1'b0;
      sd_q_reg <= 1'b0;
    end else begin
      fs_m_reg <= frame_sync;
      sd_m_reg <= sdata;
      fs_q_reg <= fs_m_reg;
      fs_d_reg <= fs_q_reg;
      sd_q_reg <= sd_m_reg;
    end
  end

  assign fs_rise = fs_q_reg && !fs_d_reg;
  assign fs_fall = !fs_q_reg && fs_d_reg;

  always_comb begin
    for (int i = 0; i < SPRX_NUM_CH; i++) begin
      logic dbl;
      logic ap;
      dbl = 1'b0;
      ap = 1'b0;
      if (i < SPRX_P0_CH) begin
        dbl = lk_cfg_reg.enable[SPRX_RATE0_BIT];
        ap = lk_cfg_reg.ap[i];
        ch_en[i] = lk_cfg_reg.enable[SPRX_EN_P0_LSB + i];
        ch_width[i] = lk_cfg_reg.width[2*i +: 2];
        ch_start[i] = lk_cfg_reg.start[9*i +: 9];
      end else begin
        dbl = lk_cfg_reg.enable[SPRX_RATE1_BIT];
        ap = SPRX_P1_AP[i - SPRX_P0_CH];
        ch_en[i] = lk_cfg_reg.enable[SPRX_EN_P1_LSB + i - SPRX_P0_CH];
        ch_width[i] = SPRX_RES_32;
        ch_start[i] = SPRX_P1_START[i - SPRX_P0_CH];
      end
      if (dbl) begin
        ch_sof[i] = fs_rise || fs_fall;
      end else if (lk_cfg_reg.split) begin
        ch_sof[i] = ap ? fs_rise : fs_fall;
      end else begin
        ch_sof[i] = fs_rise;
      end
    end
  end

  // ****************************************************************
  // Per-channel slot capture
  // ****************************************************************
  for (genvar g = 0; g < SPRX_NUM_CH; g++) begin : g_ch
    sprx_slot_capture #(.WORD_W(SPRX_DATA_W)) u_cap (
      .bclk(bclk),
      .lk_rst_n(lk_rst_n),
      .sd_i(sd_q_reg),
      .sof_i(ch_sof[g]),
      .en_i(ch_en[g]),
      .width_i(ch_width[g]),
      .start_i(ch_start[g]),
      .word_o(lk_word[g]),
      .done_tog_o(lk_done_tog[g])
    );
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == {SPRX_IDX_ENABLE, 2'b00}
    |=> enable_reg == $past(pwdata[7:0]))
    else $error("enable register did not take written value");

  phase_unused_a: assert property (@(posedge bclk) disable iff (!lk_rst_n)
    !lk_cfg_reg.split && !lk_cfg_reg.enable[SPRX_RATE0_BIT] |-> ch_sof[1] == $rose(fs_q_reg))
    else $error("phase bit acted outside split-frame mode");

  start_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((sh_reg[0] | sh_reg[1] | sh_reg[2]) & ~SPRX_SH_MASK) == 8'h00)
    else $error("reserved start-high bits set");

  status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    new_smp[0] |=> status_reg[0] ##1 status_reg[0] || $past(clr_smp[0]))
    else $error("new sample flag lost");

  split_phase_a: assert property (@(posedge bclk) disable iff (!lk_rst_n)
    ch_sof[0] && lk_cfg_reg.split && !lk_cfg_reg.enable[SPRX_RATE0_BIT]
    |-> (lk_cfg_reg.ap[0] ? $rose(fs_q_reg) : $fell(fs_q_reg)))
    else $error("split-frame start on wrong frame sync edge");

  dbl_edges_a: assert property (@(posedge bclk) disable iff (!lk_rst_n)
    lk_cfg_reg.enable[SPRX_RATE1_BIT] && (fs_q_reg != fs_d_reg) |-> ch_sof[3] && ch_sof[4])
    else $error("double rate path missed a frame edge");

  phase_ignored_a: assert property (@(posedge bclk) disable iff (!lk_rst_n)
    lk_cfg_reg.enable[SPRX_RATE0_BIT] && (fs_q_reg != fs_d_reg)
    |-> ch_sof[0] && ch_sof[1] && ch_sof[2])
    else $error("double rate first path ignored an edge");

  single_rise_a: assert property (@(posedge bclk) disable iff (!lk_rst_n)
    !lk_cfg_reg.split && !lk_cfg_reg.enable[SPRX_RATE0_BIT] && $fell(fs_q_reg) |-> !ch_sof[0])
    else $error("frame started on falling edge outside split mode");

endmodule

// ==== sprx_host_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Host side of the serial link: bit clock, frame sync, data
// ****************************************************************
module sprx_host_model (
  output logic bclk,
  output logic frame_sync,
  output logic sdata
);
  initial begin
    bclk = 1'b0;
    frame_sync = 1'b0;
    sdata = 1'b0;
  end

  // Lines move while the clock is low, the device samples on the rise
  task automatic tick(input logic fs, input logic d);
    frame_sync = fs;
    sdata = d;
    #40;
    bclk = 1'b1;
    #40;
    bclk = 1'b0;
  endtask

  // Filler clocks: data flips each bit so a stale value is never seen
  task automatic idle(input int n);
    repeat (n) tick(frame_sync, ~sdata);
  endtask

  // Frame sync high for the first half bits, bit 0 goes with its rise
  task automatic frame(input int len, input int half, input logic [511:0] pat);
    for (int p = 0; p < len; p++) begin
      tick(p < half, pat[p]);
    end
  endtask
endmodule

// ==== sprx_top_test.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module sprx_top_test;
  import sprx_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bclk;
  logic frame_sync;
  logic sdata;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic err;
  logic [511:0] pat;

  sprx_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bclk(bclk), .frame_sync(frame_sync), .sdata(sdata));

  sprx_host_model host (.bclk(bclk), .frame_sync(frame_sync), .sdata(sdata));

  always #4 pclk = ~pclk;

  // ****************************************************************
  // Reporting and bus tasks
  // ****************************************************************
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      results();
    end
  endtask

  task automatic wrreg(input logic [13:0] idx, input logic [7:0] v);
    apb(1'b1, {idx, 2'b00}, {24'h0, v});
  endtask

  task automatic rdreg(input logic [13:0] idx);
    apb(1'b0, {idx, 2'b00}, 32'h0);
  endtask

  // ****************************************************************
  // Expectation functions
  // ****************************************************************
  function automatic logic [31:0] slot_val(input logic [511:0] p, input int s, input int w);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < w; i++) begin
      v = {v[30:0], p[s+i]};
    end
    return v;
  endfunction

  // Double rate or a low active phase in split mode: frame starts at the fall
  function automatic int sof_pos(input logic split, input logic dbl, input logic ph);
    if (dbl || (split && !ph)) begin
      return 256;
    end
    return 0;
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] en;
    logic [7:0] pw [0:2];
    logic [7:0] sh [0:2];
    logic split;
    int st [0:2];
    int base;
    void'($urandom(94));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    host.idle(4);
    rdreg(SPRX_IDX_ENABLE);
    `CHK(rd, 32'h0)
    for (int c = 0; c < 3; c++) begin
      rdreg(SPRX_IDX_PW[c]);
      `CHK(rd, {24'h0, SPRX_PW_RST})
      rdreg(SPRX_IDX_SH[c]);
      `CHK(rd, 32'h0)
      rdreg(SPRX_IDX_SL[c]);
      `CHK(rd, 32'h0)
    end
    // Unaligned write is dropped, unmapped read gives zero with an error
    apb(1'b1, {SPRX_IDX_ENABLE, 2'b01}, 32'hff);
    `CHK(err, 1'b1)
    rdreg(SPRX_IDX_ENABLE);
    `CHK(rd, 32'h0)
    rdreg(14'h2a0b);
    `CHK({err, rd}, 33'h100000000)
    $display("test registers done");
    for (int t = 0; t < 12; t++) begin
      split = t[1];
      // second path opened in the first two trials to exercise it, random enables after
      en = (t < 2) ? 8'hfc : 8'($urandom);
      for (int c = 0; c < 3; c++) begin
        // Double rate restarts at the fall, so the slot fits half a frame
        st[c] = $urandom_range(0, (split || en[0]) ? 223 : 479);
        pw[c] = 8'($urandom);
        pw[c][1:0] = 2'(t + c);
        sh[c] = {7'($urandom), 1'(st[c] >> 8)};
      end
      if (t == 1) begin
        st = '{256, 479, 0};
        sh[0][0] = 1'b1;
        sh[1][0] = 1'b1;
        sh[2][0] = 1'b0;
      end
      wrreg(SPRX_IDX_CTRL, {7'h0, split});
      wrreg(SPRX_IDX_ENABLE, en);
      rdreg(SPRX_IDX_ENABLE);
      `CHK(rd, {24'h0, en})
      for (int c = 0; c < 3; c++) begin
        wrreg(SPRX_IDX_PW[c], pw[c]);
        wrreg(SPRX_IDX_SH[c], sh[c]);
        wrreg(SPRX_IDX_SL[c], 8'(st[c]));
        rdreg(SPRX_IDX_PW[c]);
        `CHK(rd, {24'h0, pw[c] & SPRX_PW_MASK})
        rdreg(SPRX_IDX_SH[c]);
        `CHK(rd, {24'h0, sh[c] & SPRX_SH_MASK})
        rdreg(SPRX_IDX_SL[c]);
        `CHK(rd, {24'h0, 8'(st[c])})
      end
      wrreg(SPRX_IDX_STATUS, 8'h1f);
      for (int k = 0; k < 16; k++) begin
        pat[k*32 +: 32] = $urandom;
      end
      host.idle(8);
      host.frame(512, 256, pat);
      host.idle(8);
      repeat (8) @(posedge pclk);
      rdreg(SPRX_IDX_STATUS);
      `CHK(rd, {27'h0, en[7:6], en[4:2]})
      for (int c = 0; c < 3; c++) begin
        if (en[2+c]) begin
          base = sof_pos(split, en[0], pw[c][6]) + st[c];
          rdreg(SPRX_IDX_DATA + 14'(c));
          `CHK(rd, slot_val(pat, base, 8 * (int'(pw[c][1:0]) + 1)))
        end
      end
      for (int c = 0; c < 2; c++) begin
        if (en[6+c]) begin
          base = sof_pos(split, en[1], SPRX_P1_AP[c]) + int'(SPRX_P1_START[c]);
          rdreg(SPRX_IDX_DATA + 14'(c + 3));
          `CHK(rd, slot_val(pat, base, 32))
        end
      end
      $display("test trial %0d done", t);
    end
    results();
  end
endmodule
